// [rtl/eqs_pkg.sv]
package eqs_pkg;

	// ------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------
	localparam logic [7:0] ERR_SEL_ADDR = 8'h42;
	localparam logic [7:0] CTL_ADDR     = 8'hd2;
	localparam logic [7:0] STS_ADDR     = 8'hd3;
	localparam logic [7:0] FLOOR_ADDR   = 8'hd4;
	localparam logic [7:0] BOUNDS_ADDR  = 8'hd5;

	// ------------------------------------------------------------
	// Values after reset
	// ------------------------------------------------------------
	localparam logic [7:0] ERR_SEL_RST = 8'h1f;
	localparam logic [7:0] CTL_RST     = 8'h03;
	localparam logic [3:0] FLOOR_RST   = 4'h0;
	localparam logic [7:0] BOUNDS_RST  = 8'hf0;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int SEL_CDR_BIT     = 0;
	localparam int SEL_ENC_BIT     = 1;
	localparam int SEL_PAR_BIT     = 2;
	localparam int SEL_CHK_EN_BIT  = 3;
	localparam int SEL_LIMIT_LSB   = 4;
	localparam int CTL_RESTART_BIT = 7;
	localparam int CTL_FL_DIS_BIT  = 6;
	localparam int CTL_FLOOR_BIT   = 5;
	localparam int CTL_DWELL_LSB   = 0;
	localparam int BND_MIN_LSB     = 0;
	localparam int BND_MAX_LSB     = 4;
	localparam int GAIN_W          = 4;
	localparam int ERR_SRC_N       = 3;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int unsigned DWELL_TIME_NS    = 2620000;
	localparam int unsigned REF_PERIOD_NS    = 40;
	localparam int unsigned CLK_PERIOD_NS    = 4;
	localparam int unsigned DWELL_REF_CYCLES = 65536;
	localparam int unsigned DWELL_CYCLES     = DWELL_REF_CYCLES * REF_PERIOD_NS / CLK_PERIOD_NS;
	localparam logic [2:0]  DWELL_FIELD_RST  = 3'h3;
	localparam logic [31:0] DWELL_BASE_CYCLES = 32'(DWELL_CYCLES >> DWELL_FIELD_RST);

	// ------------------------------------------------------------
	// Search states
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		EQS_SEARCH = 2'b01,
		EQS_HOLD   = 2'b10
	} eqs_state_t;

endpackage

// [rtl/eqs_link_side.sv]
`timescale 1ns/1ps
`default_nettype none

module eqs_link_side (
	// Link clock and reset
	input  wire logic       link_clk_i,
	input  wire logic       link_srst_i,
	// Receiver status on the link clock
	input  wire logic       cdr_lock_i,
	input  wire logic [2:0] err_i,
	input  wire logic       paired_i,
	// Toward the core domain
	output logic            lock_o,
	output logic            paired_o,
	output logic      [2:0] err_tog_o
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		logic       lock;
		logic       paired;
		logic [2:0] tog;
	} eqs_link_t;

	eqs_link_t r;
	eqs_link_t n;

	// Each error pulse flips its toggle so the core side never misses one.
	always_comb begin
		n        = r;
		n.lock   = cdr_lock_i;
		n.paired = paired_i;
		n.tog    = r.tog ^ err_i;
	end

	// Register the state on the link clock.
	always_ff @(posedge link_clk_i) begin
		if (link_srst_i) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	// Outputs come straight from the registers.
	assign lock_o    = r.lock;
	assign paired_o  = r.paired;
	assign err_tog_o = r.tog;

endmodule

`default_nettype wire

// [rtl/eqs_ctrl.sv]
`timescale 1ns/1ps
`default_nettype none

module eqs_ctrl #(
	parameter logic [31:0] DWELL_BASE_CYCLES = eqs_pkg::DWELL_BASE_CYCLES
) (
	// Core clock and reset
	input  wire logic       CLK_I,
	input  wire logic       SRST_I,
	// Link clock and reset
	input  wire logic       LINK_CLK_I,
	input  wire logic       LINK_SRST_I,
	// Register port
	input  wire logic [7:0] REG_ADDR_I,
	input  wire logic       REG_WE_I,
	input  wire logic       REG_RE_I,
	input  wire logic [7:0] REG_WDATA_I,
	output logic      [7:0] REG_RDATA_O,
	// Datapath soft reset, core clock
	input  wire logic       DP_SOFT_RST_I,
	// Receiver status, link clock
	input  wire logic       CDR_LOCK_I,
	input  wire logic [2:0] LINK_ERR_I,
	input  wire logic       SER_PAIRED_I,
	// Equalizer control
	output logic      [3:0] EQ_GAIN_O,
	output logic            EQ_HOLD_O
);

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------

	// Dwell length in core cycles for a given field value.
	function automatic logic [31:0] dwell_len(input logic [2:0] f);
		return DWELL_BASE_CYCLES << f;
	endfunction

	// Next allowed gain, wrapping past the top to minimum or floor.
	function automatic logic [3:0] next_gain(input logic [3:0] g, input logic [7:0] bnd,
			input logic [3:0] flr, input logic use_floor);
		logic [3:0] lo;
		logic [3:0] hi;
		lo = bnd[eqs_pkg::BND_MIN_LSB +: eqs_pkg::GAIN_W];
		hi = bnd[eqs_pkg::BND_MAX_LSB +: eqs_pkg::GAIN_W];
		if (g >= hi || g < lo) begin
			if (use_floor && flr >= lo && flr <= hi) begin
				return flr;
			end
			return lo;
		end
		return g + 4'h1;
	endfunction

	// Number of selected error events this cycle.
	function automatic logic [1:0] count3(input logic [2:0] e);
		return {1'b0, e[0]} + {1'b0, e[1]} + {1'b0, e[2]};
	endfunction

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		eqs_pkg::eqs_state_t state;
		logic [3:0]          gain;
		logic [31:0]         timer;
		logic [7:0]          err_cnt;
		logic [7:0]          err_sel;
		logic [7:0]          ctl;
		logic [3:0]          floor_val;
		logic [7:0]          bounds;
		logic [7:0]          rdata;
		logic [2:0]          tog_s1;
		logic [2:0]          tog_s2;
		logic [2:0]          tog_s3;
		logic                lock_s1;
		logic                lock_s2;
		logic                lock_d;
		logic                paired_s1;
		logic                paired_s2;
		logic                first_done;
	} eqs_regs_t;

	eqs_regs_t r;
	eqs_regs_t n;

	logic       link_lock;
	logic       link_paired;
	logic [2:0] link_tog;

	// ------------------------------------------------------------
	// Link domain
	// ------------------------------------------------------------

	// Link-side registers that feed the crossing.
	eqs_link_side u_link (
		.link_clk_i  (LINK_CLK_I),
		.link_srst_i (LINK_SRST_I),
		.cdr_lock_i  (CDR_LOCK_I),
		.err_i       (LINK_ERR_I),
		.paired_i    (SER_PAIRED_I),
		.lock_o      (link_lock),
		.paired_o    (link_paired),
		.err_tog_o   (link_tog)
	);

	// ------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------
	logic        wr_sel;
	logic        wr_ctl;
	logic        wr_floor;
	logic        wr_bnd;
	logic        restart;
	logic        first_lock;
	logic        locked;
	logic        timer_end;
	logic        in_window;
	logic        over;
	logic [2:0]  err_evt;
	logic [31:0] dlen;
	logic [8:0]  acc;
	logic [3:0]  adv;
	logic [3:0]  min_gain;

	// Strobes, crossing results and search conditions.
	always_comb begin
		wr_sel     = REG_WE_I && REG_ADDR_I == eqs_pkg::ERR_SEL_ADDR;
		wr_ctl     = REG_WE_I && REG_ADDR_I == eqs_pkg::CTL_ADDR;
		wr_floor   = REG_WE_I && REG_ADDR_I == eqs_pkg::FLOOR_ADDR;
		wr_bnd     = REG_WE_I && REG_ADDR_I == eqs_pkg::BOUNDS_ADDR;
		locked     = r.lock_s2;
		err_evt    = (r.tog_s2 ^ r.tog_s3) & r.err_sel[eqs_pkg::SEL_PAR_BIT:eqs_pkg::SEL_CDR_BIT];
		dlen       = dwell_len(r.ctl[eqs_pkg::CTL_DWELL_LSB +: 3]);
		timer_end  = r.timer >= dlen - 32'h1;
		in_window  = r.timer >= (dlen >> 1);
		acc        = {1'b0, r.err_cnt} + {7'h00, count3(err_evt)};
		over       = r.err_sel[eqs_pkg::SEL_CHK_EN_BIT]
			&& r.err_cnt > {4'h0, r.err_sel[eqs_pkg::SEL_LIMIT_LSB +: 4]};
		first_lock = locked && !r.lock_d && r.paired_s2 && !r.first_done
			&& !r.ctl[eqs_pkg::CTL_FL_DIS_BIT];
		restart    = (wr_ctl && REG_WDATA_I[eqs_pkg::CTL_RESTART_BIT]) || DP_SOFT_RST_I
			|| first_lock;
		adv        = next_gain(r.gain, r.bounds, r.floor_val, r.ctl[eqs_pkg::CTL_FLOOR_BIT]);
		min_gain   = r.bounds[eqs_pkg::BND_MIN_LSB +: eqs_pkg::GAIN_W];
	end

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------

	// Crossing, registers, read port and the search sequencer.
	always_comb begin
		n           = r;
		n.lock_s1   = link_lock;
		n.lock_s2   = r.lock_s1;
		n.lock_d    = r.lock_s2;
		n.paired_s1 = link_paired;
		n.paired_s2 = r.paired_s1;
		n.tog_s1    = link_tog;
		n.tog_s2    = r.tog_s1;
		n.tog_s3    = r.tog_s2;

		// Register writes; the restart bit is a strobe and is never stored.
		if (wr_sel) begin
			n.err_sel = REG_WDATA_I;
		end
		if (wr_ctl) begin
			n.ctl = {1'b0, REG_WDATA_I[6:0]};
		end
		if (wr_floor) begin
			n.floor_val = REG_WDATA_I[3:0];
		end
		if (wr_bnd) begin
			n.bounds = REG_WDATA_I;
		end

		// Registered read data; unmapped offsets read as zero.
		if (REG_RE_I) begin
			unique case (REG_ADDR_I)
				eqs_pkg::ERR_SEL_ADDR: n.rdata = r.err_sel;
				eqs_pkg::CTL_ADDR:     n.rdata = r.ctl;
				eqs_pkg::STS_ADDR:     n.rdata = {2'h0, locked, r.state[1], r.gain};
				eqs_pkg::FLOOR_ADDR:   n.rdata = {4'h0, r.floor_val};
				eqs_pkg::BOUNDS_ADDR:  n.rdata = r.bounds;
				default:               n.rdata = 8'h00;
			endcase
		end

		// Errors build up only in the second half of the dwell.
		if (in_window) begin
			n.err_cnt = acc[8] ? 8'hff : acc[7:0];
		end
		n.timer = r.timer + 32'h1;

		unique case (r.state)
			eqs_pkg::EQS_SEARCH: begin
				// Judge only when the dwell has run out.
				if (timer_end) begin
					n.timer   = 32'h0;
					n.err_cnt = 8'h00;
					if (locked && !over) begin
						n.state = eqs_pkg::EQS_HOLD;
					end else begin
						n.gain = adv;
					end
				end
			end
			eqs_pkg::EQS_HOLD: begin
				if (!locked) begin
					n.state   = eqs_pkg::EQS_SEARCH;
					n.gain    = adv;
					n.timer   = 32'h0;
					n.err_cnt = 8'h00;
				end else if (timer_end) begin
					// Gain frozen unless errors run over the limit.
					n.timer   = 32'h0;
					n.err_cnt = 8'h00;
					if (over) begin
						n.state = eqs_pkg::EQS_SEARCH;
						n.gain  = adv;
					end
				end
			end
		endcase

		// Restart wins over everything the sequencer decided.
		if (restart) begin
			n.state   = eqs_pkg::EQS_SEARCH;
			n.gain    = min_gain;
			n.timer   = 32'h0;
			n.err_cnt = 8'h00;
		end
		if (first_lock) begin
			n.first_done = 1'b1;
		end
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------

	// Register the whole state on the core clock.
	always_ff @(posedge CLK_I) begin
		if (SRST_I) begin
			r            <= '0;
			r.state      <= eqs_pkg::EQS_SEARCH;
			r.gain       <= eqs_pkg::BOUNDS_RST[eqs_pkg::BND_MIN_LSB +: eqs_pkg::GAIN_W];
			r.err_sel    <= eqs_pkg::ERR_SEL_RST;
			r.ctl        <= eqs_pkg::CTL_RST;
			r.floor_val  <= eqs_pkg::FLOOR_RST;
			r.bounds     <= eqs_pkg::BOUNDS_RST;
		end else begin
			r <= n;
		end
	end

	// Outputs come straight from the registers.
	assign REG_RDATA_O = r.rdata;
	assign EQ_GAIN_O   = r.gain;
	assign EQ_HOLD_O   = r.state[1];

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (SRST_I);

	a_search_to_hold: assert property (
		r.state == eqs_pkg::EQS_SEARCH && timer_end && locked && !over && !restart
		|=> r.state == eqs_pkg::EQS_HOLD && $stable(EQ_GAIN_O))
		else $error("lock at dwell end did not hold the gain");

	a_dwell_wait: assert property (
		r.state == eqs_pkg::EQS_SEARCH && $past(r.state) == eqs_pkg::EQS_SEARCH
		&& $changed(EQ_GAIN_O) |-> $past(timer_end) || $past(restart))
		else $error("gain changed before the dwell ran out");

	a_hold_freeze: assert property (
		r.state == eqs_pkg::EQS_HOLD && locked && !restart && !(timer_end && over)
		|=> $stable(EQ_GAIN_O) && EQ_HOLD_O)
		else $error("gain moved while lock held");

	a_lock_loss_step: assert property (
		r.state == eqs_pkg::EQS_HOLD && !locked && !restart
		|=> r.state == eqs_pkg::EQS_SEARCH && EQ_GAIN_O == $past(adv) && r.timer == 32'h0)
		else $error("lock loss did not resume the search");

	a_restart_min: assert property (
		wr_ctl && REG_WDATA_I[eqs_pkg::CTL_RESTART_BIT]
		|=> EQ_GAIN_O == $past(min_gain) && r.state == eqs_pkg::EQS_SEARCH
		&& r.ctl[eqs_pkg::CTL_RESTART_BIT] == 1'b0)
		else $error("restart bit did not restart at the minimum");

	a_first_lock_once: assert property (
		first_lock |=> r.first_done && EQ_GAIN_O == $past(min_gain) ##1 !first_lock [*3])
		else $error("first-lock restart misbehaved");

	a_status_read: assert property (
		REG_RE_I && REG_ADDR_I == eqs_pkg::STS_ADDR
		|=> REG_RDATA_O[3:0] == $past(EQ_GAIN_O) && REG_RDATA_O[7:6] == 2'h0)
		else $error("status read did not show the gain");

	a_wrap_low: assert property (
		r.state == eqs_pkg::EQS_SEARCH && timer_end && !(locked && !over) && !restart
		&& r.gain >= r.bounds[7:4] && !r.ctl[eqs_pkg::CTL_FLOOR_BIT]
		|=> EQ_GAIN_O == $past(min_gain))
		else $error("search did not wrap to the minimum");

	a_err_window: assert property (
		!in_window |=> r.err_cnt == $past(r.err_cnt) || r.err_cnt == 8'h00)
		else $error("errors counted outside the window");

	a_err_step: assert property (
		timer_end && locked && over && !restart
		|=> r.state == eqs_pkg::EQS_SEARCH && EQ_GAIN_O == $past(adv))
		else $error("error excess did not step the gain");

	c_reach_hold:  cover property (r.state == eqs_pkg::EQS_SEARCH ##1 r.state == eqs_pkg::EQS_HOLD);
	c_wrap:        cover property (timer_end && r.gain >= r.bounds[7:4] && !locked);
	c_err_step:    cover property (r.state == eqs_pkg::EQS_HOLD && timer_end && over);
	c_first_lock:  cover property (first_lock);

endmodule

`default_nettype wire

// [testbench/eqs_link_model.sv]
`timescale 1ns/1ps
`default_nettype none

module eqs_link_model (
	// Link clock
	input  wire logic       link_clk_i,
	// Gain applied at the receiver
	input  wire logic [3:0] gain_i,
	// Scenario controls
	input  wire logic       sig_on_i,
	input  wire logic [3:0] good_gain_i,
	input  wire logic       paired_i,
	input  wire logic [2:0] err_mask_i,
	input  wire logic       err_on_i,
	// Receiver status toward the controller
	output logic            cdr_lock_o,
	output logic      [2:0] err_o,
	output logic            paired_o
);
	logic ph = 1'b0;

	// Lock holds only while the gain suits the cable; errors pulse on alternate cycles.
	always @(negedge link_clk_i) begin
		ph <= ~ph;
		cdr_lock_o <= sig_on_i && (gain_i == good_gain_i);
		err_o <= (err_on_i && ph) ? err_mask_i : 3'h0;
		paired_o <= paired_i;
	end
endmodule

`default_nettype wire

// [testbench/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none

// Compares a value with its expectation and counts the outcome.
`define CHK(a, e) begin \
	checks_done++; \
	if ((a) !== (e)) begin \
		fails++; \
		$display("[ERR] %0t got %0h exp %0h", $time, (a), (e)); \
	end \
end

module tb_top;
	logic       clk = 1'b0, link_clk = 1'b0, srst = 1'b1, link_srst = 1'b1;
	logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
	logic       we = 1'b0, re = 1'b0, dp_rst = 1'b0, hold, lock, paired;
	logic       sig_on = 1'b0, pair_en = 1'b1, err_on = 1'b0;
	logic [2:0] err, err_mask = 3'h0;
	logic [3:0] gain, good = 4'h0;
	int         fails = 0, checks_done = 0, cycles = 0;

	// --------------------------------------------------------
	// Clocks, design and far side
	// --------------------------------------------------------

	// Core clock at 4 ns.
	initial begin
		forever #2 clk = ~clk;
	end

	// Link clock at 80 ns with an unrelated phase.
	initial begin
		#7;
		forever #40 link_clk = ~link_clk;
	end

	// Cuts a hang short.
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			fails++;
			print_verdict();
		end
	end

	eqs_ctrl #(.DWELL_BASE_CYCLES(32'h8)) DUT (
		.CLK_I(clk), .SRST_I(srst), .LINK_CLK_I(link_clk), .LINK_SRST_I(link_srst),
		.REG_ADDR_I(addr), .REG_WE_I(we), .REG_RE_I(re), .REG_WDATA_I(wdata),
		.REG_RDATA_O(rdata), .DP_SOFT_RST_I(dp_rst), .CDR_LOCK_I(lock),
		.LINK_ERR_I(err), .SER_PAIRED_I(paired), .EQ_GAIN_O(gain), .EQ_HOLD_O(hold));

	eqs_link_model u_far (
		.link_clk_i(link_clk), .gain_i(gain), .sig_on_i(sig_on), .good_gain_i(good),
		.paired_i(pair_en), .err_mask_i(err_mask), .err_on_i(err_on),
		.cdr_lock_o(lock), .err_o(err), .paired_o(paired));

	// --------------------------------------------------------
	// Shared tasks
	// --------------------------------------------------------

	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		we = 1'b1;
		addr = a;
		wdata = d;
		@(negedge clk);
		we = 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk);
		re = 1'b1;
		addr = a;
		@(negedge clk);
		re = 1'b0;
		d = rdata;
	endtask

	task automatic wait_chg(input logic [3:0] g, input int max, output int n);
		n = 0;
		while (gain === g && n < max) begin
			@(negedge clk);
			n++;
		end
	endtask

	task automatic wait_gain(input logic [3:0] g, input int max);
		int n;
		n = 0;
		while (gain !== g && n < max) begin
			@(negedge clk);
			n++;
		end
	endtask

	task automatic wait_hold(input int max);
		int n;
		n = 0;
		while (hold !== 1'b1 && n < max) begin
			@(negedge clk);
			n++;
		end
	endtask

	task automatic print_verdict();
		$display("checks %0d fails %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// --------------------------------------------------------
	// Scenarios
	// --------------------------------------------------------

	task automatic t_regs();
		logic [7:0] d;
		int         n;
		logic [7:0] ad [6] = '{8'h42, 8'hd2, 8'hd4, 8'hd5, 8'hd3, 8'h10};
		logic [7:0] ex [6] = '{8'h1f, 8'h03, 8'h00, 8'hf0, 8'h00, 8'h00};
		wr(8'h10, 8'h5a);
		wr(8'hd3, 8'hff);
		foreach (ad[i]) begin
			rd(ad[i], d);
			`CHK(d, ex[i])
		end
		wait_chg(4'h0, 100, n);
		`CHK(gain, 4'h1)
		$display("t_regs done");
	endtask

	task automatic t_dwell();
		int n;
		for (int f = 3; f <= 4; f++) begin
			wr(8'hd2, 8'h80 | 8'(f));
			cyc(1);
			wait_chg(4'h0, 300, n);
			`CHK(n, (8 << f) - 1)
		end
		$display("t_dwell done");
	endtask

	task automatic t_search(input logic fl);
		int         n;
		logic [3:0] g;
		wr(8'hd4, 8'h03);
		wr(8'hd5, 8'h52);
		wr(8'hd2, {2'b10, fl, 5'h04});
		cyc(1);
		`CHK(gain, 4'h2)
		for (int i = 0; i < 5; i++) begin
			g = gain;
			wait_chg(g, 300, n);
			`CHK(gain, (g == 4'h5) ? (fl ? 4'h3 : 4'h2) : g + 4'h1)
			`CHK(n, (i == 0) ? 127 : 128)
		end
		$display("t_search done");
	endtask

	task automatic t_lock();
		logic [7:0] d;
		int         n;
		wr(8'hd5, 8'h70);
		wr(8'hd2, 8'h85);
		good = 4'h3;
		sig_on = 1'b1;
		wait_gain(4'h3, 1200);
		wait_gain(4'h0, 100);
		`CHK(gain, 4'h0)
		wait_hold(1500);
		`CHK({hold, gain}, 5'h13)
		cyc(1024);
		`CHK({hold, gain}, 5'h13)
		rd(8'hd3, d);
		`CHK(d, 8'h33)
		good = 4'h6;
		wait_chg(4'h3, 100, n);
		`CHK({hold, gain}, 5'h04)
		wait_hold(1500);
		`CHK({hold, gain}, 5'h16)
		$display("t_lock done");
	endtask

	task automatic t_err();
		int n;
		for (int s = 0; s < 3; s++) begin
			wr(8'h42, 8'h18 | (8'h1 << s));
			err_mask = 3'h1 << ((s + 1) % 3);
			err_on = 1'b1;
			cyc(800);
			`CHK({hold, gain}, 5'h16)
			err_mask = 3'h1 << s;
			wait_chg(4'h6, 800, n);
			`CHK(gain, 4'h7)
			err_on = 1'b0;
			wait_hold(3000);
			`CHK({hold, gain}, 5'h16)
		end
		$display("t_err done");
	endtask

	task automatic t_rst();
		wr(8'hd2, 8'h85);
		cyc(1);
		`CHK({hold, gain}, 5'h00)
		wait_hold(3000);
		`CHK({hold, gain}, 5'h16)
		dp_rst = 1'b1;
		cyc(1);
		dp_rst = 1'b0;
		cyc(1);
		`CHK({hold, gain}, 5'h00)
		// A second reset re-arms the once-only restart; with it disabled, lock is kept at once.
		srst = 1'b1;
		link_srst = 1'b1;
		cyc(25);
		srst = 1'b0;
		link_srst = 1'b0;
		`CHK({hold, gain}, 5'h00)
		wr(8'hd2, 8'h43);
		wait_gain(4'h6, 600);
		wait_hold(100);
		`CHK({hold, gain}, 5'h16)
		$display("t_rst done");
	endtask

	// Main sequence: reset, then every scenario in turn.
	initial begin
		repeat (20) @(posedge clk);
		@(negedge clk);
		srst = 1'b0;
		link_srst = 1'b0;
		t_regs();
		t_dwell();
		t_search(1'b1);
		t_search(1'b0);
		t_lock();
		t_err();
		t_rst();
		print_verdict();
	end
endmodule

`default_nettype wire
